// File: shared/ccr_pkg.sv
// Constants, register map and carrier types of the charge channel readout sequencer
package ccr_pkg;
   // Register map
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Control fields
   localparam int CTRL_POL_BIT = 0;
   localparam int CTRL_PAR_BIT = 1;
   localparam int CTRL_FLOAT_BIT = 2;
   localparam int CTRL_RANGE_LSB = 4;
   localparam int RANGE_W = 3;
   localparam int RANGE_COUNT = 8;
   // Status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_EOC_BIT = 2;
   localparam int STAT_READY_BIT = 3;
   localparam int STAT_WAIT_BIT = 4;
   localparam int STAT_FAST_BIT = 5;
   localparam int STAT_DRV1_LSB = 8;
   localparam int STAT_DRV0_LSB = 16;
   localparam int STAT_CNT_LSB = 24;
   // Readout geometry
   localparam int CH_PER_DRV = 32;
   localparam logic [5:0] DRV1_TOP_CH = 6'h3F;
   localparam logic [5:0] DRV0_TOP_CH = 6'h1F;
   localparam logic [7:0] SEQ_STEP = 8'h04;
   localparam logic [7:0] SEQ_SKEW = 8'h02;
   localparam logic [7:0] SEQ_D1_FIRST = 8'h01;
   localparam logic [7:0] SEQ_D0_FIRST = 8'(SEQ_D1_FIRST + SEQ_SKEW);
   localparam logic [7:0] SEQ_D1_END = 8'(SEQ_D1_FIRST + CH_PER_DRV * SEQ_STEP);
   localparam logic [7:0] SEQ_D0_END = 8'(SEQ_D0_FIRST + CH_PER_DRV * SEQ_STEP);
   localparam logic [7:0] SIM_FIRST = 8'h01;
   localparam logic [7:0] SIM_END = 8'(SIM_FIRST + CH_PER_DRV);
   // Readout clock limits
   localparam int SYS_CLK_KHZ = 40000;
   localparam int SEQ_MAX_CLK_KHZ = 15000;
   localparam int SIM_MAX_CLK_KHZ = 3750;
   localparam logic [7:0] SEQ_MIN_PERIOD_CYC = 8'((SYS_CLK_KHZ + SEQ_MAX_CLK_KHZ - 1) / SEQ_MAX_CLK_KHZ);
   localparam logic [7:0] SIM_MIN_PERIOD_CYC = 8'((SYS_CLK_KHZ + SIM_MAX_CLK_KHZ - 1) / SIM_MAX_CLK_KHZ);
   // Pin inputs
   localparam int PIN_W = 4;
   localparam int PIN_START = 0;
   localparam int PIN_CLK = 1;
   localparam int PIN_CLEAR = 2;
   localparam int PIN_SAMPLE = 3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_READ = 2'b10,
      ST_WAIT = 2'b11
   } ccr_state_type;

   typedef struct packed {
      logic [RANGE_W-1:0] range;
      logic output_float_enable;
      logic parallel_readout_sel;
      logic integrate_polarity_sel;
   } ccr_ctrl_type;

   typedef struct packed {
      logic [5:0] chan;
      logic data_on;
      logic oe;
   } ccr_drv_type;
endpackage

// File: hdl/ccr_pin_filter.sv
// Three-stage pin synchroniser with agreement filter
module ccr_pin_filter #(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins and filtered levels
   input wire logic [W-1:0] pin_raw,
   output logic [W-1:0] pin_level
);
   generate
      for (genvar g = 0; g < W; g++) begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic lvl_q;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end else begin
               s1_q <= pin_raw[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         // Level changes only once stages two and three agree
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               lvl_q <= 1'b0;
            end else if (s2_q == s3_q) begin
               lvl_q <= s3_q;
            end
         end
         assign pin_level[g] = lvl_q;
      end
   endgenerate
endmodule

// File: hdl/ccr_readout_seq.sv
// Readout sequencer of a 64-channel charge-integrating front end
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
module ccr_readout_seq (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Controller pins
   input wire logic read_start_in,
   input wire logic readout_clk_in,
   input wire logic integrator_clear,
   input wire logic signal_level_sample,
   // Analog steering outputs
   output ccr_pkg::ccr_drv_type drv1,
   output ccr_pkg::ccr_drv_type drv0,
   output logic out_pos_ref_upper,
   output logic out_neg_ref_upper,
   output logic [ccr_pkg::RANGE_COUNT-1:0] fb_cap_sel,
   output logic eoc_out
);
   logic [ccr_pkg::PIN_W-1:0] pin_lvl;
   logic [ccr_pkg::PIN_W-1:0] pin_prev_q;
   logic start_rise;
   logic start_fall;
   logic clk_rise;
   logic clear_rise;
   logic sample_fall;
   ccr_pkg::ccr_ctrl_type ctrl_q;
   ccr_pkg::ccr_state_type state_q;
   logic par_mode_q;
   logic [7:0] cnt_q;
   logic [7:0] cnt_next;
   logic eoc_q;
   logic ready_q;
   logic wait_pend_q;
   logic clear_seen_q;
   logic fast_q;
   logic [7:0] period_q;
   logic read_done;
   logic aw_held_q;
   logic w_held_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic [1:0] bresp_q;
   logic bvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic rvalid_q;
   logic [31:0] status_word;
   logic fast_clear;

   ccr_pin_filter #(
      .W(ccr_pkg::PIN_W)
   ) u_pins (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_raw({signal_level_sample, integrator_clear, readout_clk_in, read_start_in}),
      .pin_level(pin_lvl)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev_q <= '0;
      end else begin
         pin_prev_q <= pin_lvl;
      end
   end

   assign start_rise = pin_lvl[ccr_pkg::PIN_START] & ~pin_prev_q[ccr_pkg::PIN_START];
   assign start_fall = ~pin_lvl[ccr_pkg::PIN_START] & pin_prev_q[ccr_pkg::PIN_START];
   assign clk_rise = pin_lvl[ccr_pkg::PIN_CLK] & ~pin_prev_q[ccr_pkg::PIN_CLK];
   assign clear_rise = pin_lvl[ccr_pkg::PIN_CLEAR] & ~pin_prev_q[ccr_pkg::PIN_CLEAR];
   assign sample_fall = ~pin_lvl[ccr_pkg::PIN_SAMPLE] & pin_prev_q[ccr_pkg::PIN_SAMPLE];

   // Analog configuration straight from the control register
   assign out_pos_ref_upper = ~ctrl_q.integrate_polarity_sel;
   assign out_neg_ref_upper = ctrl_q.integrate_polarity_sel;
   generate
      for (genvar g = 0; g < ccr_pkg::RANGE_COUNT; g++) begin : g_range
         assign fb_cap_sel[g] = (ctrl_q.range == 3'(g));
      end
   endgenerate

   // Driver state for a given edge count within its slot window
   function automatic ccr_pkg::ccr_drv_type drv_at(input logic [7:0] n, input logic [7:0] first,
                                                   input logic [7:0] last_end, input logic par,
                                                   input logic [5:0] top, input logic float_en);
      ccr_pkg::ccr_drv_type d;
      logic [7:0] idx;
      idx = par ? 8'(n - first) : 8'((n - first) >> 2);
      d.chan = top;
      d.data_on = 1'b0;
      d.oe = ~float_en;
      if (n >= first && n < last_end) begin
         d.chan = 6'(top - idx[5:0]);
         d.data_on = 1'b1;
         d.oe = 1'b1;
      end
      return d;
   endfunction

   assign cnt_next = 8'(cnt_q + 8'h01);
   assign read_done = clk_rise && (par_mode_q ? (cnt_next == ccr_pkg::SIM_END)
                                              : (cnt_next == ccr_pkg::SEQ_D0_END));

   // Sequencer state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ccr_pkg::ST_IDLE;
         cnt_q <= 8'h00;
         par_mode_q <= 1'b0;
      end else begin
         unique case (state_q)
            ccr_pkg::ST_IDLE: begin
               if (start_rise) begin
                  state_q <= ccr_pkg::ST_ARMED;
                  cnt_q <= 8'h00;
               end
            end
            ccr_pkg::ST_ARMED: begin
               cnt_q <= 8'h00;
               if (start_fall) begin
                  state_q <= ccr_pkg::ST_READ;
                  par_mode_q <= ctrl_q.parallel_readout_sel;
               end
            end
            ccr_pkg::ST_READ: begin
               if (start_rise) begin
                  state_q <= ccr_pkg::ST_ARMED;
                  cnt_q <= 8'h00;
               end else if (clk_rise) begin
                  cnt_q <= cnt_next;
                  if (read_done) begin
                     state_q <= wait_pend_q ? ccr_pkg::ST_WAIT : ccr_pkg::ST_IDLE;
                  end
               end
            end
            ccr_pkg::ST_WAIT: begin
               if (start_rise && (clear_seen_q || clear_rise)) begin
                  state_q <= ccr_pkg::ST_ARMED;
                  cnt_q <= 8'h00;
               end
            end
         endcase
      end
   end

   // Output driver steering, updated on each readout clock rising edge during a read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drv1 <= '{chan: ccr_pkg::DRV1_TOP_CH, data_on: 1'b0, oe: 1'b1};
         drv0 <= '{chan: ccr_pkg::DRV0_TOP_CH, data_on: 1'b0, oe: 1'b1};
      end else if (state_q == ccr_pkg::ST_READ && clk_rise && !start_rise) begin
         if (par_mode_q) begin
            // Both drivers together, one channel per edge
            drv1 <= drv_at(cnt_next, ccr_pkg::SIM_FIRST, ccr_pkg::SIM_END, 1'b1,
                           ccr_pkg::DRV1_TOP_CH, ctrl_q.output_float_enable);
            drv0 <= drv_at(cnt_next, ccr_pkg::SIM_FIRST, ccr_pkg::SIM_END, 1'b1,
                           ccr_pkg::DRV0_TOP_CH, ctrl_q.output_float_enable);
         end else begin
            // Four-clock slots, driver 0 two clocks behind
            drv1 <= drv_at(cnt_next, ccr_pkg::SEQ_D1_FIRST, ccr_pkg::SEQ_D1_END, 1'b0,
                           ccr_pkg::DRV1_TOP_CH, ctrl_q.output_float_enable);
            drv0 <= drv_at(cnt_next, ccr_pkg::SEQ_D0_FIRST, ccr_pkg::SEQ_D0_END, 1'b0,
                           ccr_pkg::DRV0_TOP_CH, ctrl_q.output_float_enable);
         end
      end else if (state_q != ccr_pkg::ST_READ) begin
         drv1 <= '{chan: ccr_pkg::DRV1_TOP_CH, data_on: 1'b0, oe: ~ctrl_q.output_float_enable};
         drv0 <= '{chan: ccr_pkg::DRV0_TOP_CH, data_on: 1'b0, oe: ~ctrl_q.output_float_enable};
      end
   end

   // End of conversion
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eoc_q <= 1'b1;
      end else if (start_rise && state_q != ccr_pkg::ST_WAIT) begin
         eoc_q <= 1'b0;
      end else if (start_rise && (clear_seen_q || clear_rise)) begin
         eoc_q <= 1'b0;
      end else if (state_q == ccr_pkg::ST_READ && read_done) begin
         eoc_q <= 1'b1;
      end
   end
   assign eoc_out = eoc_q;

   // Sampled data pending for the next scan
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_q <= 1'b0;
      end else if (sample_fall) begin
         ready_q <= 1'b1;
      end else if (clear_rise) begin
         ready_q <= 1'b0;
      end
   end

   // Early-read detection and wait release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_pend_q <= 1'b0;
         clear_seen_q <= 1'b0;
      end else begin
         if (start_rise && state_q != ccr_pkg::ST_WAIT) begin
            wait_pend_q <= ready_q && !clear_rise;
         end else if (state_q == ccr_pkg::ST_WAIT && start_rise && (clear_seen_q || clear_rise)) begin
            wait_pend_q <= 1'b0;
         end
         if (state_q == ccr_pkg::ST_WAIT && clear_rise) begin
            clear_seen_q <= 1'b1;
         end else if (state_q != ccr_pkg::ST_WAIT) begin
            clear_seen_q <= 1'b0;
         end
      end
   end

   // Readout clock period check, sticky, write one to clear
   assign fast_clear = do_write && awaddr_q == ccr_pkg::STATUS_OFFSET && wstrb_q[0]
                       && wdata_q[ccr_pkg::STAT_FAST_BIT];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_q <= 8'hFF;
         fast_q <= 1'b0;
      end else begin
         if (clk_rise) begin
            period_q <= 8'h01;
         end else if (period_q != 8'hFF) begin
            period_q <= 8'(period_q + 8'h01);
         end
         if (clk_rise && state_q == ccr_pkg::ST_READ &&
             period_q < 8'((ctrl_q.parallel_readout_sel ? ccr_pkg::SIM_MIN_PERIOD_CYC
                                                        : ccr_pkg::SEQ_MIN_PERIOD_CYC) - 8'h01)) begin
            fast_q <= 1'b1;
         end else if (fast_clear) begin
            fast_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite write path
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= ccr_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= (s_axi_awaddr[31:4] == 28'h000_0000) ? s_axi_awaddr[3:0] : 4'hF;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= (awaddr_q == ccr_pkg::CTRL_OFFSET || awaddr_q == ccr_pkg::STATUS_OFFSET)
                       ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= '{range: ccr_pkg::CTRL_RESET[ccr_pkg::CTRL_RANGE_LSB +: ccr_pkg::RANGE_W],
                     output_float_enable: ccr_pkg::CTRL_RESET[ccr_pkg::CTRL_FLOAT_BIT],
                     parallel_readout_sel: ccr_pkg::CTRL_RESET[ccr_pkg::CTRL_PAR_BIT],
                     integrate_polarity_sel: ccr_pkg::CTRL_RESET[ccr_pkg::CTRL_POL_BIT]};
      end else if (do_write && awaddr_q == ccr_pkg::CTRL_OFFSET && wstrb_q[0]) begin
         ctrl_q.integrate_polarity_sel <= wdata_q[ccr_pkg::CTRL_POL_BIT];
         ctrl_q.parallel_readout_sel <= wdata_q[ccr_pkg::CTRL_PAR_BIT];
         ctrl_q.output_float_enable <= wdata_q[ccr_pkg::CTRL_FLOAT_BIT];
         ctrl_q.range <= wdata_q[ccr_pkg::CTRL_RANGE_LSB +: ccr_pkg::RANGE_W];
      end
   end

   // AXI4-Lite read path
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ccr_pkg::STAT_STATE_LSB +: 2] = state_q;
      status_word[ccr_pkg::STAT_EOC_BIT] = eoc_q;
      status_word[ccr_pkg::STAT_READY_BIT] = ready_q;
      status_word[ccr_pkg::STAT_WAIT_BIT] = wait_pend_q;
      status_word[ccr_pkg::STAT_FAST_BIT] = fast_q;
      status_word[ccr_pkg::STAT_DRV1_LSB +: 6] = drv1.chan;
      status_word[ccr_pkg::STAT_DRV0_LSB +: 6] = drv0.chan;
      status_word[ccr_pkg::STAT_CNT_LSB +: 8] = cnt_q;
   end

   assign s_axi_arready = !rvalid_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= ccr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= ccr_pkg::RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         if (s_axi_araddr[31:4] != 28'h000_0000) begin
            rresp_q <= ccr_pkg::RESP_SLVERR;
         end else if (s_axi_araddr[3:0] == ccr_pkg::CTRL_OFFSET) begin
            // Same field positions as the write path
            rdata_q <= {25'h000_0000, ctrl_q.range, 1'b0, ctrl_q.output_float_enable,
                        ctrl_q.parallel_readout_sel, ctrl_q.integrate_polarity_sel};
         end else if (s_axi_araddr[3:0] == ccr_pkg::STATUS_OFFSET) begin
            rdata_q <= status_word;
         end else begin
            rresp_q <= ccr_pkg::RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule

// File: tb/ccr_readout_seq_properties.sv
// Concurrent checks on the readout sequencer ports
module ccr_readout_seq_properties (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Controller pins
   input wire logic read_start_in,
   input wire logic integrator_clear,
   // Steering outputs
   input wire ccr_pkg::ccr_drv_type drv1,
   input wire ccr_pkg::ccr_drv_type drv0,
   input wire logic out_pos_ref_upper,
   input wire logic out_neg_ref_upper,
   input wire logic [ccr_pkg::RANGE_COUNT-1:0] fb_cap_sel,
   input wire logic eoc_out
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   pol_legs_a: assert property (out_pos_ref_upper != out_neg_ref_upper)
      else $error("output legs share one reference");
   range_onehot_a: assert property ($onehot(fb_cap_sel))
      else $error("feedback select not one-hot");
   drv1_upper_a: assert property (drv1.data_on |-> drv1.chan[5] == 1'b1)
      else $error("driver 1 shows a lower-half channel");
   drv0_lower_a: assert property (drv0.data_on |-> drv0.chan[5] == 1'b0)
      else $error("driver 0 shows an upper-half channel");
   drv1_descend_a: assert property ((drv1.data_on && $past(drv1.data_on) && $changed(drv1.chan))
      |-> drv1.chan == 6'($past(drv1.chan) - 1)) else $error("driver 1 skipped a channel");
   drv0_descend_a: assert property ((drv0.data_on && $past(drv0.data_on) && $changed(drv0.chan))
      |-> drv0.chan == 6'($past(drv0.chan) - 1)) else $error("driver 0 skipped a channel");
   eoc_busy_a: assert property ((drv1.data_on || drv0.data_on) |-> !eoc_out)
      else $error("end of conversion high during transfer");
   start_arms_a: assert property (($rose(read_start_in) && $rose(integrator_clear))
      |-> ##[1:8] !eoc_out) else $error("start pulse did not begin a read");
   drive_on_a: assert property ((drv1.data_on |-> drv1.oe) and (drv0.data_on |-> drv0.oe))
      else $error("driver floated while presenting data");

   cover property ($rose(read_start_in));
   cover property ($rose(drv0.data_on));
   cover property ($rose(eoc_out));
endmodule

bind ccr_readout_seq ccr_readout_seq_properties chk (.aclk(aclk), .aresetn(aresetn),
   .read_start_in(read_start_in), .integrator_clear(integrator_clear), .drv1(drv1), .drv0(drv0),
   .out_pos_ref_upper(out_pos_ref_upper), .out_neg_ref_upper(out_neg_ref_upper),
   .fb_cap_sel(fb_cap_sel), .eoc_out(eoc_out));

// File: tb/ccr_ctrl_model.sv
// Timing controller model driving the readout pins
module ccr_ctrl_model (
   // Clock
   input wire logic aclk,
   // Pins toward the sequencer
   output logic read_start_in = 1'b0,
   output logic readout_clk_in = 1'b0,
   output logic integrator_clear = 1'b0,
   output logic signal_level_sample = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;

   task automatic hold(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Pulse widths stay above the pin filter depth
   task automatic sample_pulse();
      @(posedge aclk);
      signal_level_sample <= 1'b1;
      hold(4);
      signal_level_sample <= 1'b0;
      hold(8);
   endtask

   // Clear raised with start releases the wait state, or keeps the scan from ending in it
   task automatic start_pulse(input logic with_clear);
      @(posedge aclk);
      read_start_in <= 1'b1;
      integrator_clear <= with_clear;
      hold(4);
      read_start_in <= 1'b0;
      integrator_clear <= 1'b0;
      hold(10);
   endtask

   // One readout clock period of twice half cycles; caller keeps that period above mode limits
   task automatic clk_pulse(input int half);
      @(posedge aclk);
      readout_clk_in <= 1'b1;
      hold(half);
      readout_clk_in <= 1'b0;
      hold(half - 1);
   endtask
endmodule

// File: tb/ccr_readout_seq_bench.sv
// Register and readout sequence tests of the readout sequencer
module ccr_readout_seq_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   logic read_start_in, readout_clk_in, integrator_clear, signal_level_sample;
   logic out_pos_ref_upper, out_neg_ref_upper, eoc_out;
   logic [7:0] fb_cap_sel;
   ccr_pkg::ccr_drv_type drv1, drv0;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;

   ccr_readout_seq dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .read_start_in(read_start_in), .readout_clk_in(readout_clk_in),
      .integrator_clear(integrator_clear), .signal_level_sample(signal_level_sample), .drv1(drv1),
      .drv0(drv0), .out_pos_ref_upper(out_pos_ref_upper), .out_neg_ref_upper(out_neg_ref_upper),
      .fb_cap_sel(fb_cap_sel), .eoc_out(eoc_out));

   ccr_ctrl_model ctl (.aclk(aclk), .read_start_in(read_start_in), .readout_clk_in(readout_clk_in),
      .integrator_clear(integrator_clear), .signal_level_sample(signal_level_sample));

   initial begin
      forever #12.5 aclk = ~aclk;
   end

   task automatic final_report();
      if (failures == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Handshakes are judged at the falling edge, taken at the next rising edge
   task automatic axi_write(input logic [31:0] addr, input logic [31:0] data);
      logic aw_hs, w_hs, b_hs;
      @(posedge aclk);
      s_axi_awaddr <= addr;
      s_axi_wdata <= data;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b_hs = 1'b0;
      while (!b_hs) begin
         @(negedge aclk);
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         b_hs = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_hs) s_axi_awvalid <= 1'b0;
         if (w_hs) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [31:0] addr);
      logic ar_hs, r_hs;
      @(posedge aclk);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r_hs = 1'b0;
      while (!r_hs) begin
         @(negedge aclk);
         ar_hs = s_axi_arvalid && s_axi_arready;
         r_hs = (s_axi_rvalid === 1'b1);
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ar_hs) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   // Presenting: whole struct; otherwise common-mode or float per enable
   task automatic chk_drv(input string name, input ccr_pkg::ccr_drv_type seen, input int k, input int first,
                          input int step, input logic [5:0] top, input logic fl);
      if (k >= first && k < first + ccr_pkg::CH_PER_DRV * step) begin
         check(name, 32'(seen), 32'({6'(top - (k - first) / step), 2'b11}));
      end else begin
         check(name, 32'({seen.data_on, seen.oe}), 32'({1'b0, !fl}));
      end
   endtask

   task automatic run_read(input int n, input int half, input int first0, input int step, input logic fl);
      for (int k = 1; k <= n; k++) begin
         ctl.clk_pulse(half);
         @(negedge aclk);
         chk_drv("drv1", drv1, k, 1, step, ccr_pkg::DRV1_TOP_CH, fl);
         chk_drv("drv0", drv0, k, first0, step, ccr_pkg::DRV0_TOP_CH, fl);
         check("eoc", 32'(eoc_out), 32'(k >= n));
      end
   endtask

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      check("eoc reset", 32'(eoc_out), 32'h0000_0001);
      check("drv1 reset", 32'(drv1), 32'({ccr_pkg::DRV1_TOP_CH, 2'b01}));
      check("drv0 reset", 32'(drv0), 32'({ccr_pkg::DRV0_TOP_CH, 2'b01}));
      axi_read(32'(ccr_pkg::CTRL_OFFSET));
      check("ctrl reset", rd, ccr_pkg::CTRL_RESET);
      axi_read(32'h0000_0008);
      check("unmapped read", 32'(resp), 32'(ccr_pkg::RESP_SLVERR));
      axi_write(32'h0000_0008, 32'h0000_0001);
      check("unmapped write", 32'(resp), 32'(ccr_pkg::RESP_SLVERR));
      for (int r = 0; r < ccr_pkg::RANGE_COUNT; r++) begin
         for (int p = 0; p < 2; p++) begin
            axi_write(32'(ccr_pkg::CTRL_OFFSET), 32'((r << ccr_pkg::CTRL_RANGE_LSB) | p));
            @(negedge aclk);
            check("range sel", 32'(fb_cap_sel), 32'(8'h01 << r));
            check("pos leg", 32'(out_pos_ref_upper), 32'(p == 0));
            check("neg leg", 32'(out_neg_ref_upper), 32'(p == 1));
         end
      end
      axi_read(32'(ccr_pkg::CTRL_OFFSET));
      check("ctrl readback", rd, 32'(((ccr_pkg::RANGE_COUNT - 1) << ccr_pkg::CTRL_RANGE_LSB) | 1));
      axi_write(32'(ccr_pkg::CTRL_OFFSET), 32'h0000_0000);
      ctl.sample_pulse();
      axi_read(32'(ccr_pkg::STATUS_OFFSET));
      check("data ready", 32'(rd[ccr_pkg::STAT_READY_BIT]), 32'h0000_0001);
      ctl.start_pulse(1'b0);
      run_read(131, 5, 3, 4, 1'b0);
      axi_read(32'(ccr_pkg::STATUS_OFFSET));
      check("wait state", 32'(rd[1:0]), 32'(ccr_pkg::ST_WAIT));
      check("seq clock ok", 32'(rd[ccr_pkg::STAT_FAST_BIT]), 32'h0000_0000);
      ctl.start_pulse(1'b0);
      axi_read(32'(ccr_pkg::STATUS_OFFSET));
      check("wait kept", 32'(rd[1:0]), 32'(ccr_pkg::ST_WAIT));
      axi_write(32'(ccr_pkg::CTRL_OFFSET), 32'h0000_0006);
      ctl.start_pulse(1'b1);
      axi_read(32'(ccr_pkg::STATUS_OFFSET));
      check("read state", 32'(rd[1:0]), 32'(ccr_pkg::ST_READ));
      check("ready cleared", 32'(rd[ccr_pkg::STAT_READY_BIT]), 32'h0000_0000);
      run_read(33, 6, 1, 1, 1'b1);
      axi_read(32'(ccr_pkg::STATUS_OFFSET));
      check("idle state", 32'(rd[1:0]), 32'(ccr_pkg::ST_IDLE));
      check("sim clock ok", 32'(rd[ccr_pkg::STAT_FAST_BIT]), 32'h0000_0000);
      final_report();
   end
endmodule
